// ### verilog/clg_pkg.sv
// constants, types and register map of the look-up table glue block
package clg_pkg;

  localparam int NUM_TABLES = 2;
  localparam int FILTER_STAGES = 4;

  // register offsets, byte wide registers on a 5-bit address
  localparam logic [4:0] GLOBAL_CONTROL_OFS = 5'h00;
  localparam logic [4:0] STATE_ELEMENT_CONTROL_OFS = 5'h01;
  localparam logic [4:0] STATUS_OFS = 5'h02;
  localparam logic [4:0] TABLE_BASE_OFS = 5'h08;
  localparam logic [1:0] TABLE_CONTROL_A_SUB = 2'h0;
  localparam logic [1:0] TABLE_CONTROL_B_SUB = 2'h1;
  localparam logic [1:0] TABLE_CONTROL_C_SUB = 2'h2;
  localparam logic [1:0] TABLE_PATTERN_SUB = 2'h3;

  // field positions
  localparam int GLOBAL_EN_BIT = 0;
  localparam int CTLA_EN_BIT = 0;
  localparam int CTLA_EDGE_BIT = 3;
  localparam int CTLA_FILT_LSB = 4;
  localparam int CTLA_TABLE_CLOCK_SOURCE_SELECT_BIT = 6;
  localparam int CTLB_IN0_LSB = 0;
  localparam int CTLB_IN1_LSB = 4;
  localparam int CTLC_IN2_LSB = 0;
  localparam int STE_FUNC_LSB = 0;

  // values after reset
  localparam logic [7:0] REG_RESET = 8'h00;

  typedef enum logic [3:0] {
    SRC_MASKED = 4'h0,
    SRC_FEEDBACK = 4'h1,
    SRC_LINK = 4'h2,
    SRC_EVENT0 = 4'h3,
    SRC_EVENT1 = 4'h4,
    SRC_PIN = 4'h5,
    SRC_COMPARATOR = 4'h6,
    SRC_TIMER_WAVE = 4'h7
  } clg_src_e;

  typedef enum logic [1:0] {
    FILT_OFF = 2'h0,
    FILT_SYNC = 2'h1,
    FILT_FILTER = 2'h2
  } clg_filt_e;

  typedef enum logic [2:0] {
    STE_OFF = 3'h0,
    STE_D_FLIP_FLOP = 3'h1,
    STE_TOGGLE_CAPABLE_FLOP = 3'h2,
    STE_GATED_TRANSPARENT_LATCH = 3'h3,
    STE_SET_RESET_LATCH = 3'h4
  } clg_ste_e;

  typedef struct packed {
    logic clock_source;
    logic [1:0] filter;
    logic edge_detect;
    logic [7:0] pattern;
  } clg_unit_cfg_s;

endpackage

// ### verilog/clg_table_unit.sv
// one look-up table with its filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module clg_table_unit
  import clg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic active,
  input wire logic clock_tick,
  input wire logic [2:0] in_lines,
  input wire clg_unit_cfg_s cfg,
  output logic table_output_line
);

  logic [2:0] index;
  logic raw;
  logic [FILTER_STAGES-1:0] stage_q;
  logic filt_q;
  logic filt_val;
  logic prev_q;

  always_comb begin
    index = {in_lines[2] & ~cfg.clock_source, in_lines[1:0]};
    raw = cfg.pattern[index];
  end

  // cleared whenever the table is off
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      stage_q <= '0;
    end else if (!active) begin
      stage_q <= '0;
    end else if (clock_tick) begin
      stage_q <= {stage_q[FILTER_STAGES-2:0], raw};
    end
  end

  // filter only passes a level that stood three ticks
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_q <= 1'b0;
    end else if (!active) begin
      filt_q <= 1'b0;
    end else if (clock_tick && stage_q[3:1] == {3{stage_q[1]}}) begin
      filt_q <= stage_q[1];
    end
  end

  always_comb begin
    case (cfg.filter)
      FILT_OFF: filt_val = raw;
      FILT_SYNC: filt_val = stage_q[1];
      FILT_FILTER: filt_val = filt_q;
      default: filt_val = raw;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
    end else if (!active) begin
      prev_q <= 1'b0;
    end else if (clock_tick) begin
      prev_q <= filt_val;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      table_output_line <= 1'b0;
    end else if (!active) begin
      table_output_line <= 1'b0;
    end else if (cfg.edge_detect) begin
      table_output_line <= filt_val & ~prev_q & clock_tick;
    end else begin
      table_output_line <= filt_val;
    end
  end

endmodule
`default_nettype wire

// ### verilog/clg_state_element.sv
// shared sequential element of the table pair
`timescale 1ns/1ps
`default_nettype none
module clg_state_element
  import clg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic clock_tick,
  input wire clg_ste_e func,
  input wire logic even_in,
  input wire logic odd_in,
  output logic state_element_output
);

  // latches are sampled every cycle: no true transparent path
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_element_output <= 1'b0;
    end else if (clear) begin
      state_element_output <= 1'b0;
    end else begin
      case (func)
        STE_D_FLIP_FLOP: begin
          if (clock_tick && odd_in) begin
            state_element_output <= even_in;
          end
        end
        STE_TOGGLE_CAPABLE_FLOP: begin
          if (clock_tick) begin
            case ({even_in, odd_in})
              2'b01: state_element_output <= 1'b0;
              2'b10: state_element_output <= 1'b1;
              2'b11: state_element_output <= ~state_element_output;
              default: state_element_output <= state_element_output;
            endcase
          end
        end
        STE_GATED_TRANSPARENT_LATCH: begin
          if (odd_in) begin
            state_element_output <= even_in;
          end
        end
        STE_SET_RESET_LATCH: begin
          // both high is forbidden; hold is the safe reading
          if (even_in && !odd_in) begin
            state_element_output <= 1'b1;
          end else if (odd_in && !even_in) begin
            state_element_output <= 1'b0;
          end
        end
        default: state_element_output <= 1'b0;
      endcase
    end
  end

endmodule
`default_nettype wire

// ### verilog/clg_top.sv
// look-up table glue block: registers, input routing, tables, state element
`timescale 1ns/1ps
`default_nettype none
module clg_top
  import clg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [5:0] table_input_lines,
  input wire logic [1:0] event_in,
  input wire logic comparator_out,
  input wire logic [2:0] timer_wave,
  output logic [1:0] table_output_line,
  output logic state_element_output
);

  function automatic logic [4:0] table_reg(input logic idx,
                                           input logic [1:0] sub);
    table_reg = TABLE_BASE_OFS + {2'b00, idx, 2'b00} + {3'b000, sub};
  endfunction

  function automatic logic pick_src(input logic [3:0] sel,
                                    input logic fb,
                                    input logic link,
                                    input logic [1:0] ev,
                                    input logic pin,
                                    input logic cmp,
                                    input logic tw);
    case (clg_src_e'(sel))
      SRC_MASKED: pick_src = 1'b0;
      SRC_FEEDBACK: pick_src = fb;
      SRC_LINK: pick_src = link;
      SRC_EVENT0: pick_src = ev[0];
      SRC_EVENT1: pick_src = ev[1];
      SRC_PIN: pick_src = pin;
      SRC_COMPARATOR: pick_src = cmp;
      SRC_TIMER_WAVE: pick_src = tw;
      default: pick_src = 1'b0;
    endcase
  endfunction

  logic [5:0] pin_meta_q;
  logic [5:0] pin_sync_q;
  logic global_en_q;
  logic [7:0] ste_ctrl_q;
  logic [7:0] ctla_q [NUM_TABLES];
  logic [7:0] ctlb_q [NUM_TABLES];
  logic [7:0] ctlc_q [NUM_TABLES];
  logic [7:0] pattern_q [NUM_TABLES];
  logic [NUM_TABLES-1:0] active;
  logic [NUM_TABLES-1:0] tick;
  logic [NUM_TABLES-1:0] clk_line;
  logic [NUM_TABLES-1:0] clk_prev_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic ste_q;

  // pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= table_input_lines;
      pin_sync_q <= pin_meta_q;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_en_q <= 1'b0;
    end else if (reg_write && reg_addr == GLOBAL_CONTROL_OFS) begin
      global_en_q <= reg_wdata[GLOBAL_EN_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ste_ctrl_q <= REG_RESET;
    end else if (reg_write && reg_addr == STATE_ELEMENT_CONTROL_OFS &&
                 !ctla_q[0][CTLA_EN_BIT]) begin
      ste_ctrl_q <= reg_wdata;
    end
  end

  // there is no halt input, debug cannot stop the block

  for (genvar n = 0; n < NUM_TABLES; n++) begin : g_table
    localparam int LINK = (n + 1) % NUM_TABLES;
    logic [2:0] in_val;
    logic [3:0] sel;
    clg_unit_cfg_s cfg;

    // control A: enable always, other fields only while off
    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctla_q[n] <= REG_RESET;
      end else if (reg_write &&
                   reg_addr == table_reg(1'(n), TABLE_CONTROL_A_SUB)) begin
        if (!ctla_q[n][CTLA_EN_BIT]) begin
          // a write that leaves the table off changes nothing
          if (reg_wdata[CTLA_EN_BIT]) begin
            ctla_q[n] <= reg_wdata;
          end
        end else begin
          ctla_q[n][CTLA_EN_BIT] <= reg_wdata[CTLA_EN_BIT];
        end
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctlb_q[n] <= REG_RESET;
      end else if (reg_write && !ctla_q[n][CTLA_EN_BIT] &&
                   reg_addr == table_reg(1'(n), TABLE_CONTROL_B_SUB)) begin
        ctlb_q[n] <= reg_wdata;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        ctlc_q[n] <= REG_RESET;
      end else if (reg_write && !ctla_q[n][CTLA_EN_BIT] &&
                   reg_addr == table_reg(1'(n), TABLE_CONTROL_C_SUB)) begin
        ctlc_q[n] <= reg_wdata;
      end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        pattern_q[n] <= REG_RESET;
      end else if (reg_write &&
                   reg_addr == table_reg(1'(n), TABLE_PATTERN_SUB)) begin
        pattern_q[n] <= reg_wdata;
      end
    end

    // link takes the neighbour's registered output to avoid a loop
    always_comb begin
      in_val = '0;
      sel = '0;
      for (int i = 0; i < 3; i++) begin
        case (i)
          0: sel = ctlb_q[n][CTLB_IN0_LSB +: 4];
          1: sel = ctlb_q[n][CTLB_IN1_LSB +: 4];
          default: sel = ctlc_q[n][CTLC_IN2_LSB +: 4];
        endcase
        in_val[i] = pick_src(sel, ste_q, table_output_line[LINK],
                             event_in, pin_sync_q[3*n+i],
                             comparator_out, timer_wave[i]);
      end
    end

    always_comb begin
      active[n] = global_en_q & ctla_q[n][CTLA_EN_BIT];
      clk_line[n] = in_val[2];
      // a live switch of the source may give one stray tick
      if (ctla_q[n][CTLA_TABLE_CLOCK_SOURCE_SELECT_BIT]) begin
        tick[n] = clk_line[n] & ~clk_prev_q[n];
      end else begin
        tick[n] = 1'b1;
      end
      cfg.clock_source = ctla_q[n][CTLA_TABLE_CLOCK_SOURCE_SELECT_BIT];
      cfg.filter = ctla_q[n][CTLA_FILT_LSB +: 2];
      cfg.edge_detect = ctla_q[n][CTLA_EDGE_BIT];
      cfg.pattern = pattern_q[n];
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
        clk_prev_q[n] <= 1'b0;
      end else begin
        clk_prev_q[n] <= clk_line[n];
      end
    end

    clg_table_unit u_unit (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .active(active[n]),
      .clock_tick(tick[n]),
      .in_lines(in_val),
      .cfg(cfg),
      .table_output_line(table_output_line[n])
    );
  end

  clg_state_element u_state (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clear(~active[0]),
    .clock_tick(tick[0]),
    .func(clg_ste_e'(ste_ctrl_q[STE_FUNC_LSB +: 3])),
    .even_in(table_output_line[0]),
    .odd_in(table_output_line[1]),
    .state_element_output(ste_q)
  );

  assign state_element_output = ste_q;

  // read data only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (reg_addr == GLOBAL_CONTROL_OFS) begin
      rdata_d = {7'h00, global_en_q};
    end else if (reg_addr == STATE_ELEMENT_CONTROL_OFS) begin
      rdata_d = ste_ctrl_q;
    end else if (reg_addr == STATUS_OFS) begin
      rdata_d = {5'h00, ste_q, table_output_line};
    end
    for (int n = 0; n < NUM_TABLES; n++) begin
      if (reg_addr == table_reg(1'(n), TABLE_CONTROL_A_SUB)) begin
        rdata_d = ctla_q[n];
      end else if (reg_addr == table_reg(1'(n), TABLE_CONTROL_B_SUB)) begin
        rdata_d = ctlb_q[n];
      end else if (reg_addr == table_reg(1'(n), TABLE_CONTROL_C_SUB)) begin
        rdata_d = ctlc_q[n];
      end else if (reg_addr == table_reg(1'(n), TABLE_PATTERN_SUB)) begin
        rdata_d = pattern_q[n];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_read) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = rdata_q;

endmodule
`default_nettype wire

// ### bench/clg_top_sva.sv
// port checker of the look-up table glue block
`timescale 1ns/1ps
`default_nettype none
module clg_top_sva
  import clg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] table_input_lines,
  input wire logic [1:0] event_in,
  input wire logic comparator_out,
  input wire logic [2:0] timer_wave,
  input wire logic [1:0] table_output_line,
  input wire logic state_element_output
);
  localparam logic [4:0] A0 = TABLE_BASE_OFS;
  localparam logic [4:0] B0 = TABLE_BASE_OFS + 5'h01;
  localparam logic [4:0] A1 = TABLE_BASE_OFS + 5'h04;
  localparam logic [4:0] SE = STATE_ELEMENT_CONTROL_OFS;
  logic g_q;
  logic e0_q;
  logic e1_q;
  logic [7:0] b0_q;
  logic [2:0] s_q;
  logic rd_q;
  logic [4:0] ra_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_q <= 1'b0;
      ra_q <= 5'h00;
    end else begin
      rd_q <= reg_read;
      ra_q <= reg_addr;
    end
  end

  // shadow of what software set; locked fields follow table 0 enable only
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      g_q <= 1'b0;
      e0_q <= 1'b0;
      e1_q <= 1'b0;
      b0_q <= REG_RESET;
      s_q <= 3'h0;
    end else if (reg_write) begin
      if (reg_addr == GLOBAL_CONTROL_OFS) g_q <= reg_wdata[GLOBAL_EN_BIT];
      if (reg_addr == A0) e0_q <= reg_wdata[CTLA_EN_BIT];
      if (reg_addr == A1) e1_q <= reg_wdata[CTLA_EN_BIT];
      if (reg_addr == B0 && !e0_q) b0_q <= reg_wdata;
      if (reg_addr == SE && !e0_q) s_q <= reg_wdata[2:0];
    end
  end

  AST_GLOBAL_OFF: assert property (
    !g_q [*2] |-> table_output_line == 2'b00 && !state_element_output)
    else $error("output active while block disabled");
  AST_T0_OFF: assert property (
    !e0_q [*2] |-> !table_output_line[0] && !state_element_output)
    else $error("table 0 or element active while table 0 off");
  AST_T1_OFF: assert property (
    !e1_q [*2] |-> !table_output_line[1])
    else $error("table 1 active while off");
  AST_B0_PROT: assert property (
    rd_q && ra_q == B0 |-> reg_rdata == $past(b0_q))
    else $error("input select changed while table enabled");
  AST_FUNC_PROT: assert property (
    rd_q && ra_q == SE |-> reg_rdata[2:0] == $past(s_q))
    else $error("element function changed while table 0 enabled");
  AST_EN_READ: assert property (
    rd_q && ra_q == GLOBAL_CONTROL_OFS |-> reg_rdata[0] == $past(g_q))
    else $error("global enable readback wrong");
  AST_A_EN_READ: assert property (
    rd_q && ra_q == A0 |-> reg_rdata[0] == $past(e0_q))
    else $error("table enable readback wrong");
  AST_STATUS: assert property (
    rd_q && ra_q == STATUS_OFS |-> reg_rdata ==
      {5'h00, $past(state_element_output), $past(table_output_line)})
    else $error("status differs from outputs");

  cover property (rd_q && ra_q == STATUS_OFS && reg_rdata[2]);
  cover property (reg_write && reg_addr == B0 && e0_q);
  cover property (reg_write && reg_addr == SE && e0_q);
endmodule

bind clg_top clg_top_sva i_clg_top_sva (.sys_clk, .rst_n, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .table_input_lines,
  .event_in, .comparator_out, .timer_wave, .table_output_line,
  .state_element_output);
`default_nettype wire

// ### bench/clg_far_side.sv
// model of the pins, event lines, comparator and timer beside the block
`timescale 1ns/1ps
`default_nettype none
module clg_far_side (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [11:0] want,
  output logic [5:0] pins,
  output logic [1:0] events,
  output logic comparator,
  output logic [2:0] timer
);
  initial pins = 6'h00;

  // on-chip sources move on the clock edge like real peripherals
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      {timer, comparator, events} <= 6'h00;
    end else begin
      {timer, comparator, events} <= want[11:6];
    end
  end

  // pins are unrelated to the clock: they move mid-cycle
  always @(posedge sys_clk) begin
    pins <= #2 want[5:0];
  end
endmodule
`default_nettype wire

// ### bench/clg_top_tb.sv
// self-checking bench of the look-up table glue block
`timescale 1ns/1ps
`default_nettype none
module clg_top_tb
  import clg_pkg::*;
;
  localparam logic [4:0] A0 = TABLE_BASE_OFS;
  localparam logic [4:0] B0 = TABLE_BASE_OFS + 5'h01;
  localparam logic [4:0] C0 = TABLE_BASE_OFS + 5'h02;
  localparam logic [4:0] P0 = TABLE_BASE_OFS + 5'h03;
  localparam logic [4:0] A1 = TABLE_BASE_OFS + 5'h04;
  localparam logic [4:0] B1 = TABLE_BASE_OFS + 5'h05;
  localparam logic [4:0] C1 = TABLE_BASE_OFS + 5'h06;
  localparam logic [4:0] P1 = TABLE_BASE_OFS + 5'h07;
  localparam logic [4:0] SE = STATE_ELEMENT_CONTROL_OFS;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [11:0] want = 12'h000;
  logic [7:0] reg_rdata;
  logic [5:0] pins;
  logic [1:0] events;
  logic comparator;
  logic [2:0] timer;
  logic [1:0] outs;
  logic seo;
  logic [7:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] seed;
  logic [7:0] p0;
  logic [7:0] p1;
  int fail_count = 0;
  int comparisons = 0;

  always #2.5 sys_clk = ~sys_clk;

  clg_far_side i_clg_far_side (.sys_clk, .rst_n, .want, .pins, .events,
    .comparator, .timer);
  clg_top i_clg_top (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .table_input_lines(pins), .event_in(events),
    .comparator_out(comparator), .timer_wave(timer),
    .table_output_line(outs), .state_element_output(seo));

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
    comparisons++;
    if (seen !== expv) begin
      fail_count++;
      $display("[ERR] %0t read %h expected %h", $time, seen, expv);
    end
  endtask

  // strobes are set on entry only, so back-to-back calls never clash
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rd(input logic [4:0] a, input logic [7:0] expv);
    exp_q.push_back(expv);
    reg_addr <= a;
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic idle(input int n);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask

  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // read data stands only in the cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_seen) chk(reg_rdata, exp_q.pop_front());
    rd_seen <= reg_read;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    $display("[ERR] %0t run did not finish", $time);
    end_sim;
  end

  initial begin
    seed = 8'h29;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    for (int a = 0; a < 16; a++) rd(5'(a), REG_RESET);
    rd(5'h1F, 8'h00);
    seed = lfsr(seed);
    p0 = seed;
    seed = lfsr(seed);
    p1 = seed;
    wr(B0, {SRC_EVENT1, SRC_EVENT0});
    wr(C0, {4'h0, SRC_COMPARATOR});
    wr(P0, p0);
    wr(B1, {SRC_MASKED, SRC_TIMER_WAVE});
    wr(C1, {4'h0, SRC_PIN});
    wr(P1, p1);
    wr(A0, 8'h01);
    wr(A1, 8'h01);
    wr(GLOBAL_CONTROL_OFS, 8'h01);
    // masked line 1 of table 1 is driven high to prove it reads low
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      want <= {seed[5:4], i[0], i[2], i[1:0], i[2], 1'b1, seed[3:0]};
      idle(6);
      rd(STATUS_OFS, {6'h00, p1[{i[2], 1'b0, i[0]}], p0[i[2:0]]});
    end
    wr(P0, 8'hFF);
    wr(GLOBAL_CONTROL_OFS, 8'h00);
    idle(4);
    rd(STATUS_OFS, 8'h00);
    rd(GLOBAL_CONTROL_OFS, 8'h00);
    wr(B0, 8'h77);
    rd(B0, {SRC_EVENT1, SRC_EVENT0});
    wr(A0, 8'h41);
    rd(A0, 8'h01);
    wr(A0, 8'h40);
    rd(A0, 8'h00);
    wr(A0, 8'h11);
    rd(A0, 8'h11);
    wr(SE, 8'h02);
    rd(SE, 8'h00);
    wr(A0, 8'h00);
    rd(A0, 8'h10);
    wr(A0, 8'h20);
    rd(A0, 8'h10);
    wr(SE, 8'h03);
    rd(SE, 8'h03);
    // both tables now pass line 0 straight through
    wr(P0, 8'hAA);
    wr(P1, 8'hAA);
    wr(GLOBAL_CONTROL_OFS, 8'h01);
    for (int f = 1; f < 5; f++) begin
      wr(A0, 8'h00);
      wr(SE, 8'(f));
      wr(A0, 8'h01);
      want <= {2'b00, f[0], 1'b0, 2'b01, 6'h00};
      idle(6);
      rd(STATUS_OFS, {5'h00, 1'b1, f[0], 1'b1});
      want <= {2'b00, 1'b1, 1'b0, 2'b00, 6'h00};
      idle(6);
      rd(STATUS_OFS, 8'h02);
    end
    want <= 12'h040;
    idle(6);
    wr(A1, 8'h00);
    wr(C1, {4'h0, SRC_FEEDBACK});
    wr(P1, 8'hF0);
    wr(A1, 8'h01);
    idle(6);
    rd(STATUS_OFS, 8'h07);
    // line 2 used as clock must read low in the index
    wr(GLOBAL_CONTROL_OFS, 8'h00);
    wr(A0, 8'h00);
    wr(P0, 8'hF0);
    wr(A0, 8'h41);
    rd(A0, 8'h41);
    wr(GLOBAL_CONTROL_OFS, 8'h01);
    want <= 12'h100;
    idle(6);
    rd(STATUS_OFS, 8'h00);
    idle(2);
    end_sim;
  end
endmodule
`default_nettype wire
